//--- hdl/fsrb_pkg.sv
package fsrb_pkg;
  // ===================================================================
  // bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ===================================================================
  // register offsets
  localparam logic [15:0] OFS_SW_HIGH    = 16'h054E;
  localparam logic [15:0] OFS_SW_LOW     = 16'h054F;
  localparam logic [15:0] OFS_CMP_MISC   = 16'h0550;
  localparam logic [15:0] OFS_SUP_FIRST  = 16'h0552;
  localparam logic [15:0] OFS_SUP_SECOND = 16'h0553;
  localparam logic [15:0] OFS_SUP_THIRD  = 16'h0554;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'h0560;
  localparam logic [15:0] OFS_IRQ_MASK   = 16'h0561;
  localparam logic [15:0] OFS_FAULT_CLR  = 16'h0562;

  // ===================================================================
  // select indices, also irq and clear bit positions per register
  localparam int SEL_SW_HIGH    = 0;
  localparam int SEL_SW_LOW     = 1;
  localparam int SEL_CMP_MISC   = 2;
  localparam int SEL_SUP_FIRST  = 3;
  localparam int SEL_SUP_SECOND = 4;
  localparam int SEL_SUP_THIRD  = 5;
  localparam int SEL_IRQ_STATUS = 6;
  localparam int SEL_IRQ_MASK   = 7;
  localparam int SEL_FAULT_CLR  = 8;
  localparam int NUM_REGS       = 6;
  localparam int NUM_SEL        = 9;

  // ===================================================================
  // field positions
  localparam int FILTER_FAIL_BIT  = 0;
  localparam int CMP_ABORT_BIT    = 1;
  localparam int COMM_GND_BIT     = 7;
  localparam int DIG_GND_BIT      = 6;
  localparam int REF_LOW_BIT      = 5;
  localparam int COMM_UNDER_BIT   = 4;
  localparam int COMM_OVER_BIT    = 3;
  localparam int DIG_OVER_BIT     = 2;
  localparam int AN_WOBBLE_BIT    = 1;
  localparam int AN_OVER_BIT      = 0;
  localparam int SELFTEST_BIT     = 6;
  localparam int HREF_WOBBLE_BIT  = 4;
  localparam int PUMP_UNDER_BIT   = 3;
  localparam int THERM_WOBBLE_BIT = 2;
  localparam int THERM_UNDER_BIT  = 1;
  localparam int THERM_OVER_BIT   = 0;
  localparam int AN_RESET_BIT     = 0;

  // ===================================================================
  // reset and reserved-bit values
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] CMP_MISC_MASK   = 8'h03;
  localparam logic [7:0] SUP_SECOND_MASK = 8'h5F;
  localparam logic [7:0] SUP_THIRD_MASK  = 8'h01;

  // ===================================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic              wr;
    logic              rd;
  } fsrb_bus_t;

  typedef struct packed {
    logic        cbDone;
    logic [15:0] cbFail;
    logic        lpfDone;
    logic        lpfFail;
    logic        cmpDone;
    logic        cmpAborted;
  } fsrb_diag_t;

  typedef struct packed {
    logic commGroundOpen;
    logic digitalGroundOpen;
    logic referenceLowOpen;
    logic commSupplyUnder;
    logic commSupplyOver;
    logic digitalSupplyOver;
    logic analogSupplyWobble;
    logic analogSupplyOver;
    logic supplySelftestFail;
    logic highReferenceWobble;
    logic negativePumpUnder;
    logic thermistorReferenceWobble;
    logic thermistorReferenceUnder;
    logic thermistorReferenceOver;
    logic analogUnderDigitalReset;
  } fsrb_supply_t;
endpackage

//--- hdl/fsrb_sync.sv
`timescale 1ns/1ns
module fsrb_sync
  import fsrb_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  logic             clk,
  input  logic             rst_n,
  input  logic             ce,
  // levels
  input  logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] filt
);
  // ===================================================================
  // three stages; the first is read only by the second
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] mid;
    logic [WIDTH-1:0] late;
    logic [WIDTH-1:0] filt;
  } fsrb_sync_t;

  fsrb_sync_t st;
  fsrb_sync_t next_st;

  always_comb begin
    next_st      = st;
    next_st.meta = raw;
    next_st.mid  = st.meta;
    next_st.late = st.mid;
    // a glitch shorter than two samples never reaches the output
    next_st.filt = (st.mid & st.late) | (st.filt & (st.mid | st.late));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign filt = st.filt;
endmodule

//--- hdl/fsrb_sticky.sv
`timescale 1ns/1ns
module fsrb_sticky
  import fsrb_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  logic             clk,
  input  logic             rst_n,
  input  logic             ce,
  // set and clear
  input  logic [WIDTH-1:0] set,
  input  logic [WIDTH-1:0] clr,
  // flags
  output logic [WIDTH-1:0] q,
  output logic [WIDTH-1:0] rise
);
  // ===================================================================
  // state
  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } fsrb_sticky_t;

  fsrb_sticky_t st;
  fsrb_sticky_t next_st;

  always_comb begin
    next_st = st;
    // set is or-ed in after the clear so an event is never lost
    next_st.flags = (st.flags & ~clr) | set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign q    = st.flags;
  assign rise = ce ? (set & ~st.flags) : '0;
endmodule

//--- hdl/fsrb_fault_bank.sv
// Operation
// R1 - switches nine to sixteen results in high register, switch sixteen bit 7
// R2 - switches one to eight results in low register, switch one bit 0
// R3 - abort bit set on aborted comparison, cleared on completed one
// R4 - filter check result in bit 0 of comparison register
// R5 - comm supply under bit 4, over bit 3, digital over bit 2
// R6 - analog supply wobble sets bit 1 of first supply register
// R7 - host ignores and clears spurious wobble after wake from sleep
// R8 - analog supply overvoltage sets bit 0 of first supply register
// R9 - supply self-test failure sets bit 6 of second register
// R10 - high reference wobble sets bit 4 of second register
// R11 - negative pump undervoltage sets bit 3 of second register
// R12 - thermistor reference wobble sets bit 2 of second register
// R13 - thermistor reference undervoltage sets bit 1 of second register
// R14 - ground and reference-low open flags in bits 7, 6, 5
// R15 - thermistor over bit 0 second, reset cause bit 0 third
// R16 - fault registers read-only, reset zero, reserved bits read zero
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module fsrb_fault_bank
  import fsrb_pkg::*;
(
  // clock and reset
  input  logic              clk,
  input  logic              rst_n,
  input  logic              ce,
  // register port
  input  fsrb_bus_t         bus,
  output logic [DATA_W-1:0] rdData,
  // diagnostic results
  input  fsrb_diag_t        diag,
  // supervisor levels
  input  fsrb_supply_t      rawSupply,
  // interrupt
  output logic              irq
);
  // ===================================================================
  // address decode
  function automatic logic [NUM_SEL-1:0] decodeAddr(
    input logic [ADDR_W-1:0] a
  );
    logic [NUM_SEL-1:0] s;
    s = '0;
    case (a)
      OFS_SW_HIGH:    s[SEL_SW_HIGH]    = 1'b1;
      OFS_SW_LOW:     s[SEL_SW_LOW]     = 1'b1;
      OFS_CMP_MISC:   s[SEL_CMP_MISC]   = 1'b1;
      OFS_SUP_FIRST:  s[SEL_SUP_FIRST]  = 1'b1;
      OFS_SUP_SECOND: s[SEL_SUP_SECOND] = 1'b1;
      OFS_SUP_THIRD:  s[SEL_SUP_THIRD]  = 1'b1;
      OFS_IRQ_STATUS: s[SEL_IRQ_STATUS] = 1'b1;
      OFS_IRQ_MASK:   s[SEL_IRQ_MASK]   = 1'b1;
      OFS_FAULT_CLR:  s[SEL_FAULT_CLR]  = 1'b1;
      default:        s = '0;
    endcase
    return s;
  endfunction

  logic [NUM_SEL-1:0]  wrSel;
  logic [NUM_SEL-1:0]  rdSel;
  logic [NUM_REGS-1:0] clrCmd;

  assign wrSel  = bus.wr ? decodeAddr(bus.addr) : '0;
  assign rdSel  = bus.rd ? decodeAddr(bus.addr) : '0;
  assign clrCmd = wrSel[SEL_FAULT_CLR] ? bus.wrData[NUM_REGS-1:0] : '0;

  // ===================================================================
  // state
  typedef struct packed {
    logic [7:0]          swHigh;
    logic [7:0]          swLow;
    logic                abortFlag;
    logic                filterFail;
    logic [NUM_REGS-1:0] irqMask;
    logic [DATA_W-1:0]   rdData;
  } fsrb_bank_t;

  fsrb_bank_t st;
  fsrb_bank_t next_st;

  // ===================================================================
  // supervisor capture
  fsrb_supply_t  supFilt;
  fsrb_supply_t  supLatch;
  logic [14:0]   supClr;
  logic [14:0]   supRise;
  logic [7:0]    supFirst;
  logic [7:0]    supSecond;
  logic [7:0]    supThird;

  // analog comparators sit outside this clock domain
  fsrb_sync #(
    .WIDTH ($bits(fsrb_supply_t))
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .raw   (rawSupply),
    .filt  (supFilt)
  );

  // faults stay latched until software clears them
  assign supClr = {{8{clrCmd[SEL_SUP_FIRST]}},
                   {6{clrCmd[SEL_SUP_SECOND]}},
                   clrCmd[SEL_SUP_THIRD]}; // R7

  fsrb_sticky #(
    .WIDTH ($bits(fsrb_supply_t))
  ) u_latch (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .set   (supFilt),
    .clr   (supClr),
    .q     (supLatch),
    .rise  (supRise)
  );

  always_comb begin
    supFirst  = REG_RESET;
    supSecond = REG_RESET;
    supThird  = REG_RESET;
    supFirst[COMM_GND_BIT]       = supLatch.commGroundOpen; // R14
    supFirst[DIG_GND_BIT]        = supLatch.digitalGroundOpen; // R14
    supFirst[REF_LOW_BIT]        = supLatch.referenceLowOpen; // R14
    supFirst[COMM_UNDER_BIT]     = supLatch.commSupplyUnder; // R5
    supFirst[COMM_OVER_BIT]      = supLatch.commSupplyOver; // R5
    supFirst[DIG_OVER_BIT]       = supLatch.digitalSupplyOver; // R5
    supFirst[AN_WOBBLE_BIT]      = supLatch.analogSupplyWobble; // R6
    supFirst[AN_OVER_BIT]        = supLatch.analogSupplyOver; // R8
    supSecond[SELFTEST_BIT]      = supLatch.supplySelftestFail; // R9
    supSecond[HREF_WOBBLE_BIT]   = supLatch.highReferenceWobble; // R10
    supSecond[PUMP_UNDER_BIT]    = supLatch.negativePumpUnder; // R11
    supSecond[THERM_WOBBLE_BIT]  =
      supLatch.thermistorReferenceWobble; // R12
    supSecond[THERM_UNDER_BIT]   =
      supLatch.thermistorReferenceUnder; // R13
    supSecond[THERM_OVER_BIT]    =
      supLatch.thermistorReferenceOver; // R15
    supThird[AN_RESET_BIT]       =
      supLatch.analogUnderDigitalReset; // R15
  end

  // ===================================================================
  // interrupt events and status
  logic [NUM_REGS-1:0] evt;
  logic [NUM_REGS-1:0] irqClr;
  logic [NUM_REGS-1:0] irqStatus;
  logic [NUM_REGS-1:0] irqRise;

  always_comb begin
    evt = '0;
    evt[SEL_SW_HIGH]    = ce & diag.cbDone &
                          (|(diag.cbFail[15:8] & ~st.swHigh));
    evt[SEL_SW_LOW]     = ce & diag.cbDone &
                          (|(diag.cbFail[7:0] & ~st.swLow));
    evt[SEL_CMP_MISC]   = ce & ((diag.lpfDone & diag.lpfFail &
                                 ~st.filterFail) |
                                (diag.cmpDone & diag.cmpAborted &
                                 ~st.abortFlag));
    evt[SEL_SUP_FIRST]  = |supRise[14:7];
    evt[SEL_SUP_SECOND] = |supRise[6:1];
    evt[SEL_SUP_THIRD]  = supRise[0];
  end

  // write one to clear; an event in the same cycle still wins
  assign irqClr = wrSel[SEL_IRQ_STATUS] ? bus.wrData[NUM_REGS-1:0] : '0;

  fsrb_sticky #(
    .WIDTH (NUM_REGS)
  ) u_irq (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .set   (evt),
    .clr   (irqClr),
    .q     (irqStatus),
    .rise  ()
  );

  assign irqRise = evt & st.irqMask;
  assign irq     = |(irqStatus & st.irqMask);

  // ===================================================================
  // read mux, unmapped and reserved positions read zero
  logic [DATA_W-1:0] rdValue;

  always_comb begin
    rdValue = REG_RESET;
    case (1'b1)
      rdSel[SEL_SW_HIGH]:    rdValue = st.swHigh;
      rdSel[SEL_SW_LOW]:     rdValue = st.swLow;
      rdSel[SEL_CMP_MISC]:   rdValue = {6'h00, st.abortFlag,
                                        st.filterFail} & CMP_MISC_MASK;
      rdSel[SEL_SUP_FIRST]:  rdValue = supFirst;
      rdSel[SEL_SUP_SECOND]: rdValue = supSecond & SUP_SECOND_MASK; // R16
      rdSel[SEL_SUP_THIRD]:  rdValue = supThird & SUP_THIRD_MASK; // R16
      rdSel[SEL_IRQ_STATUS]: rdValue = {2'h0, irqStatus};
      rdSel[SEL_IRQ_MASK]:   rdValue = {2'h0, st.irqMask};
      default:               rdValue = REG_RESET;
    endcase
  end

  // ===================================================================
  // next state; writes to the fault registers themselves are ignored
  always_comb begin
    next_st = st;
    next_st.rdData = bus.rd ? rdValue : REG_RESET;
    if (wrSel[SEL_IRQ_MASK]) begin
      next_st.irqMask = bus.wrData[NUM_REGS-1:0];
    end
    if (clrCmd[SEL_SW_HIGH]) begin
      next_st.swHigh = REG_RESET;
    end
    if (clrCmd[SEL_SW_LOW]) begin
      next_st.swLow = REG_RESET;
    end
    if (clrCmd[SEL_CMP_MISC]) begin
      next_st.abortFlag  = 1'b0;
      next_st.filterFail = 1'b0;
    end
    // a finishing diagnostic wins over a clear in the same cycle
    if (diag.cbDone) begin
      next_st.swHigh = diag.cbFail[15:8]; // R1
      next_st.swLow  = diag.cbFail[7:0]; // R2
    end
    if (diag.cmpDone) begin
      next_st.abortFlag = diag.cmpAborted; // R3
    end
    if (diag.lpfDone) begin
      next_st.filterFail = diag.lpfFail; // R4
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0; // R16
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rdData = st.rdData;

  // ===================================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence commUnderHeld;
    (ce && rawSupply.commSupplyUnder) [*5];
  endsequence

  sequence selftestHeld;
    (ce && rawSupply.supplySelftestFail) [*5];
  endsequence

  sequence thermWobbleHeld;
    (ce && rawSupply.thermistorReferenceWobble) [*5];
  endsequence

  sequence clearFirst;
    ce && wrSel[SEL_FAULT_CLR] && bus.wrData[SEL_SUP_FIRST];
  endsequence

  AST_SW_HIGH_LOAD: assert property ( // R1
    ce && diag.cbDone |=> st.swHigh == $past(diag.cbFail[15:8]))
    else $error("high switch results not loaded");

  AST_SW_LOW_LOAD: assert property ( // R2
    ce && diag.cbDone |=> st.swLow == $past(diag.cbFail[7:0]))
    else $error("low switch results not loaded");

  AST_CMP_ABORT_SET: assert property ( // R3
    ce && diag.cmpDone && diag.cmpAborted |=> st.abortFlag)
    else $error("abort flag not set");

  AST_CMP_ABORT_CLEAR: assert property ( // R3
    ce && diag.cmpDone && !diag.cmpAborted |=> !st.abortFlag)
    else $error("abort flag not cleared on completion");

  AST_FILTER_RESULT: assert property ( // R4
    ce && diag.lpfDone
    |=> rdSel[SEL_CMP_MISC] || st.filterFail == $past(diag.lpfFail))
    else $error("filter result not stored");

  AST_COMM_UNDER: assert property ( // R5
    commUnderHeld |=> supFirst[COMM_UNDER_BIT])
    else $error("comm undervoltage not flagged");

  AST_FIRST_READBACK: assert property ( // R5
    ce && rdSel[SEL_SUP_FIRST] |=> rdData == $past(supFirst))
    else $error("first supply register read wrong");

  AST_AN_WOBBLE: assert property ( // R6
    ce && supFilt.analogSupplyWobble |=> supFirst[AN_WOBBLE_BIT])
    else $error("analog wobble not flagged");

  AST_HOST_CLEAR: assert property ( // R7
    clearFirst and !supFilt.analogSupplyWobble
    |=> !supFirst[AN_WOBBLE_BIT])
    else $error("wobble flag not cleared by host");

  AST_AN_OVER: assert property ( // R8
    $rose(supFirst[AN_OVER_BIT]) |-> $past(supFilt.analogSupplyOver))
    else $error("analog overvoltage set without cause");

  AST_SELFTEST: assert property ( // R9
    selftestHeld |=> supSecond[SELFTEST_BIT])
    else $error("self-test failure not flagged");

  AST_HREF_WOBBLE: assert property ( // R10
    $rose(supSecond[HREF_WOBBLE_BIT])
    |-> $past(supFilt.highReferenceWobble))
    else $error("high reference wobble set without cause");

  AST_PUMP_UNDER: assert property ( // R11
    ce && supFilt.negativePumpUnder |=> supSecond[PUMP_UNDER_BIT])
    else $error("pump undervoltage not flagged");

  AST_THERM_WOBBLE: assert property ( // R12
    thermWobbleHeld |=> supSecond[THERM_WOBBLE_BIT])
    else $error("thermistor wobble not flagged");

  AST_THERM_UNDER: assert property ( // R13
    $rose(supSecond[THERM_UNDER_BIT])
    |-> $past(supFilt.thermistorReferenceUnder))
    else $error("thermistor undervoltage set without cause");

  AST_REF_LOW_OPEN: assert property ( // R14
    ce && supFilt.referenceLowOpen ##1 ce && rdSel[SEL_SUP_FIRST]
    |=> rdData[REF_LOW_BIT])
    else $error("reference low open not readable");

  AST_RESET_CAUSE: assert property ( // R15
    ce && supFilt.analogUnderDigitalReset |=> supThird[AN_RESET_BIT])
    else $error("reset cause not flagged");

  AST_RESERVED_ZERO: assert property ( // R16
    ce && rdSel[SEL_SUP_SECOND]
    |=> (rdData & ~SUP_SECOND_MASK) == 8'h00)
    else $error("reserved bits read nonzero");

  AST_FAULT_READ_ONLY: assert property ( // R16
    ce && wrSel[SEL_SUP_FIRST] && supFirst[COMM_OVER_BIT]
    |=> supFirst[COMM_OVER_BIT])
    else $error("write altered a read-only fault");

  AST_IRQ_EVENT: assert property (
    irqRise[SEL_SUP_FIRST] |=> irq [*2])
    else $error("unmasked event did not raise interrupt");
endmodule

//--- tb/fsrb_fault_bank_tb.sv
`timescale 1ns/1ns
module fsrb_fault_bank_tb;
  import fsrb_pkg::*;

  // ==================================================================
  // clock, reset and design hookup
  logic              clk;
  logic              rst_n;
  logic              ce;
  fsrb_bus_t         bus;
  logic [DATA_W-1:0] rdData;
  fsrb_diag_t        diag;
  fsrb_supply_t      rawSupply;
  logic              irq;
  int                mismatches;
  int                n_checks;
  int                seed;
  logic [7:0]        got;
  logic [15:0]       cbVal;

  fsrb_fault_bank u_fsrb_fault_bank (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .bus       (bus),
    .rdData    (rdData),
    .diag      (diag),
    .rawSupply (rawSupply),
    .irq       (irq)
  );

  always #20 clk = ~clk;

  // ==================================================================
  // expected values, worked out from the register layout
  function automatic logic [15:0] supAddr(int i);
    if (i < 8) return OFS_SUP_FIRST;
    if (i < 14) return OFS_SUP_SECOND;
    return OFS_SUP_THIRD;
  endfunction

  function automatic logic [7:0] supData(int i);
    logic [7:0] second [6];
    second = '{8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
    if (i < 8) return 8'h80 >> i;
    if (i < 14) return second[i-8];
    return 8'h01;
  endfunction

  function automatic int supSel(int i);
    if (i < 8) return SEL_SUP_FIRST;
    if (i < 14) return SEL_SUP_SECOND;
    return SEL_SUP_THIRD;
  endfunction

  // ==================================================================
  // checking and ending
  task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==================================================================
  // register port master: strobes last one cycle
  task automatic regWrite(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    bus.addr   <= a;
    bus.wrData <= d;
    bus.wr     <= 1'b1;
    @(posedge clk);
    bus.wr     <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic regRead(logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd   <= 1'b0;
    #1;
    d = rdData;
  endtask

  task automatic readChk(string what, logic [15:0] a, logic [7:0] exp);
    logic [7:0] v;
    regRead(a, v);
    chk(what, exp, v);
  endtask

  task automatic chkIrq(logic exp);
    #1;
    chk("irq", {7'h00, exp}, {7'h00, irq});
  endtask

  // done strobes are one-cycle pulses carrying their result
  task automatic pulseDiag(int which, logic [15:0] fail, logic bitv);
    @(posedge clk);
    diag.cbFail     <= fail;
    diag.lpfFail    <= bitv;
    diag.cmpAborted <= bitv;
    diag.cbDone     <= (which == 0);
    diag.lpfDone    <= (which == 1);
    diag.cmpDone    <= (which == 2);
    @(posedge clk);
    diag.cbDone  <= 1'b0;
    diag.lpfDone <= 1'b0;
    diag.cmpDone <= 1'b0;
  endtask

  // ==================================================================
  // watchdog: whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  // ==================================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    bus = '0;
    diag = '0;
    rawSupply = '0;
    mismatches = 0;
    n_checks = 0;
    seed = 29295;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chkIrq(1'b0);
    // reset values, then writes must not stick
    for (int r = 0; r < 7; r++) begin
      readChk("reset", 16'h054E + 16'(r), 8'h00);
    end
    for (int r = 0; r < 7; r++) begin
      regWrite(16'h054E + 16'(r), 8'($random(seed)) | 8'h01);
      readChk("ro", 16'h054E + 16'(r), 8'h00);
    end
    // balancing switches: corners then random words
    for (int k = 0; k < 10; k++) begin
      cbVal = (k == 0) ? 16'h8001 : (k == 1) ? 16'hFFFF : 16'($random(seed));
      pulseDiag(0, cbVal, 1'b0);
      readChk("swHigh", OFS_SW_HIGH, cbVal[15:8]);
      readChk("swLow", OFS_SW_LOW, cbVal[7:0]);
    end
    // filter and abort bits, reserved bits stay low
    pulseDiag(1, 16'hFFFF, 1'b1);
    readChk("misc", OFS_CMP_MISC, 8'h01);
    pulseDiag(2, 16'hFFFF, 1'b1);
    readChk("misc", OFS_CMP_MISC, 8'h03);
    pulseDiag(2, 16'hFFFF, 1'b0);
    readChk("misc", OFS_CMP_MISC, 8'h01);
    pulseDiag(1, 16'h0000, 1'b0);
    readChk("misc", OFS_CMP_MISC, 8'h00);
    // each supervisor alone, latched after it drops, then cleared
    for (int i = 0; i < 15; i++) begin
      @(posedge clk);
      rawSupply <= 15'h4000 >> i;
      repeat (8) @(posedge clk);
      readChk("supSet", supAddr(i), supData(i));
      rawSupply <= '0;
      repeat (8) @(posedge clk);
      readChk("supHeld", supAddr(i), supData(i));
      regWrite(OFS_FAULT_CLR, 8'h01 << supSel(i));
      readChk("supClr", supAddr(i), 8'h00);
    end
    // all faults at once: reserved positions read zero
    @(posedge clk);
    rawSupply <= '1;
    repeat (8) @(posedge clk);
    readChk("first", OFS_SUP_FIRST, 8'hFF);
    readChk("second", OFS_SUP_SECOND, SUP_SECOND_MASK);
    readChk("third", OFS_SUP_THIRD, SUP_THIRD_MASK);
    rawSupply <= '0;
    repeat (8) @(posedge clk);
    regWrite(OFS_FAULT_CLR, 8'h38);
    regWrite(OFS_IRQ_STATUS, 8'h3F);
    readChk("irqSt", OFS_IRQ_STATUS, 8'h00);
    // spurious wobble on wake: masked, unmasked, then host clears it
    @(posedge clk);
    rawSupply.analogSupplyWobble <= 1'b1;
    repeat (8) @(posedge clk);
    rawSupply.analogSupplyWobble <= 1'b0;
    readChk("irqSt", OFS_IRQ_STATUS, 8'h08);
    chkIrq(1'b0);
    regWrite(OFS_IRQ_MASK, 8'h08);
    chkIrq(1'b1);
    readChk("irqMask", OFS_IRQ_MASK, 8'h08);
    repeat (8) @(posedge clk);
    regWrite(OFS_FAULT_CLR, 8'h08);
    regWrite(OFS_IRQ_STATUS, 8'h08);
    chkIrq(1'b0);
    readChk("wobbleClr", OFS_SUP_FIRST, 8'h00);
    // unmapped place reads zero
    readChk("unmapped", 16'h0551, 8'h00);
    finish_test();
  end
endmodule
